// ### rsc_reset_source_control.sv
// Reset source controller: power-on, pin, undervoltage and soft resets.
// Assumes synchronous pin and comparator inputs and a one-cycle register port.
// Functional notes
// - Power-on reset holds CPU, restarts at zero.
// - Power-on reset presets all port registers high.
// - Selected pin held low resets the CPU.
// - Extra delay after pin release before running.
// - Pin reset keeps port registers unchanged.
// - Pin select codes: 0x55 I/O, 0xAA reset.
// - Other pin select codes reset after delay.
// - That soft reset sets cause flag bit 3.
// - Pin select 0x55 at power-on and resets.
// - Reset pin selection overrides other pin sharing.
// - Upper four flag bits read as zero.
// - Bit 3 cleared only by software.
// - Low supply must persist before resetting.
// - Decode five thresholds and the disable code.
// - Illegal threshold code: delayed reset, flag, restore.
// - Real undervoltage reset keeps threshold register.
// - Monitoring off in idle or sleep.
// - Threshold register powers up as 0x66.
// - Undervoltage event sets flag bit 2.
// - Watchdog code fault sets flag bit 0.
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_source_control
  import rsc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       extResetNPin,
  input  wire logic       supplyLow,
  input  wire logic       lowPowerMode,
  input  wire logic       wdtCtrlFault,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  output logic            cpuReset,
  output logic            portPreset,
  output logic            resetPinEnable,
  output logic            lvMonitorEn,
  output logic      [2:0] lvThreshold
);

  rsc_state_e state, next_state;
  logic [7:0] pinSelect, next_pinSelect;
  logic [7:0] lowVoltageSelect, next_lowVoltageSelect;
  logic [3:0] causeFlags, flagSet;
  logic       causePin, causeLv, holdByPin;
  logic       softStart, softDone, relStart, relDone;
  logic       lvFire, pinResetReq, holdReq, softBad, enterHold, fromSoft;
  logic       wrEn, wrPin, wrFlags, wrLv;

  // Software writes land only while the CPU runs
  assign wrEn    = regWr && (state == ST_RUN);
  assign wrPin   = wrEn && (regAddr == ADDR_PIN_SELECT);
  assign wrFlags = wrEn && (regAddr == ADDR_CAUSE_FLAGS);
  assign wrLv    = wrEn && (regAddr == ADDR_LV_SELECT);

  // Reset requests from pin, supply and corrupted selection codes
  assign pinResetReq = resetPinEnable && !extResetNPin;
  assign holdReq     = (holdByPin && !extResetNPin) || (lvMonitorEn && supplyLow);
  assign softBad     = !pinSelValid(pinSelect) || !lvCodeValid(lowVoltageSelect);
  assign enterHold   = (next_state == ST_HOLD) && (state != ST_HOLD);
  assign fromSoft    = (state == ST_SOFT_WAIT) && softDone;
  assign softStart   = (next_state == ST_SOFT_WAIT) && (state != ST_SOFT_WAIT);
  assign relStart    = (next_state == ST_RELEASE) && (state != ST_RELEASE);

  // Sequencer: pin, supply and watchdog faults win over soft faults
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (pinResetReq || lvFire || wdtCtrlFault) begin
          next_state = ST_HOLD;
        end else if (softBad) begin
          next_state = ST_SOFT_WAIT;
        end
      end
      ST_SOFT_WAIT: begin
        if (pinResetReq || lvFire || wdtCtrlFault || softDone) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!holdReq) begin
          next_state = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (pinResetReq || lvFire) begin
          next_state = ST_HOLD;
        end else if (relDone) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_HOLD;
      end
    endcase
  end

  // State register; power-on enters hold then the release delay
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // Soft reset delay timer
  rsc_delay_timer uSoftTimer (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .start     (softStart),
    .loadValue (SOFT_RESET_LOAD),
    .done      (softDone)
  );

  // Delay after the reset line rises again
  rsc_delay_timer uReleaseTimer (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .start     (relStart),
    .loadValue (PIN_RELEASE_LOAD),
    .done      (relDone)
  );

  // Low-supply persistence filter
  rsc_supply_filter uSupplyFilter (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .monitorEn (lvMonitorEn),
    .supplyLow (supplyLow),
    .qualified (lvFire)
  );

  // Remember which code was corrupt when the soft wait starts
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      causePin <= 1'b0;
      causeLv  <= 1'b0;
    end else if (softStart) begin
      causePin <= !pinSelValid(pinSelect);
      causeLv  <= !lvCodeValid(lowVoltageSelect);
    end
  end

  // A pin reset holds until the line rises, even after select restore
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      holdByPin <= 1'b0;
    end else if (enterHold) begin
      holdByPin <= pinResetReq;
    end else if (next_state != ST_HOLD) begin
      holdByPin <= 1'b0;
    end
  end

  // Next pin selection: every reset made here restores it
  always_comb begin
    next_pinSelect = pinSelect;
    if (enterHold) begin
      next_pinSelect = PIN_SELECT_POR;
    end else if (wrPin) begin
      next_pinSelect = regWdata;
    end
  end

  // Next threshold code: only its own corruption restores it
  always_comb begin
    next_lowVoltageSelect = lowVoltageSelect;
    if (fromSoft && causeLv) begin
      next_lowVoltageSelect = LV_SELECT_POR;
    end else if (wrLv) begin
      next_lowVoltageSelect = regWdata;
    end
  end

  // Selection registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinSelect        <= PIN_SELECT_POR;
      lowVoltageSelect <= LV_SELECT_POR;
    end else begin
      pinSelect        <= next_pinSelect;
      lowVoltageSelect <= next_lowVoltageSelect;
    end
  end

  // Hardware set events for the cause flags
  always_comb begin
    flagSet                = 4'h0;
    flagSet[FLAG_PIN_SEL]  = fromSoft && causePin;
    flagSet[FLAG_UV_EVENT] = lvFire;
    flagSet[FLAG_UV_SEL]   = fromSoft && causeLv;
    flagSet[FLAG_WDT]      = wdtCtrlFault;
  end

  // Sticky flags: zero written clears, one keeps, set beats clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      causeFlags <= CAUSE_FLAGS_POR;
    end else if (wrFlags) begin
      causeFlags <= (causeFlags & regWdata[3:0]) | flagSet;
    end else begin
      causeFlags <= causeFlags | flagSet;
    end
  end

  // CPU reset covers hold and release; PC restarts at zero after it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpuReset <= 1'b1;
    end else begin
      cpuReset <= (next_state == ST_HOLD) || (next_state == ST_RELEASE);
    end
  end

  // Port preset only from power-on; other resets leave ports alone
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      portPreset <= 1'b1;
    end else if (next_state == ST_RUN) begin
      portPreset <= 1'b0;
    end
  end

  // Reset function claims the shared pin over other sharing controls
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resetPinEnable <= 1'b0;
    end else begin
      resetPinEnable <= (next_pinSelect == PIN_SEL_RESET);
    end
  end

  // Monitor enable and threshold index for the comparator
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lvMonitorEn <= 1'b0;
      lvThreshold <= THR_NONE;
    end else begin
      lvMonitorEn <= (lvThresholdIndex(next_lowVoltageSelect) != THR_NONE)
                     && !lowPowerMode;
      lvThreshold <= lvThresholdIndex(next_lowVoltageSelect);
    end
  end

  // Read port: data in the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (sys_rst || !regRd) begin
      regRdata <= READ_IDLE;
    end else begin
      case (regAddr)
        ADDR_PIN_SELECT:  regRdata <= pinSelect;
        ADDR_CAUSE_FLAGS: regRdata <= {UPPER_ZERO, causeFlags};
        ADDR_LV_SELECT:   regRdata <= lowVoltageSelect;
        default:          regRdata <= READ_IDLE;
      endcase
    end
  end

  // Cycles spent in the current state, for the timing checks
  logic [TIMER_W-1:0] stateCyc;
  always_ff @(posedge clk) begin
    if (sys_rst || (next_state != state)) begin
      stateCyc <= TIMER_ZERO;
    end else begin
      stateCyc <= stateCyc + TIMER_ONE;
    end
  end

  default clocking cbMain @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Power-on leaves the CPU in reset with ports preset
  property p_por_hold;
    $fell(sys_rst) |-> cpuReset && portPreset && (state == ST_HOLD);
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("power-on not held");
  // Port preset only ever rises out of power-on
  property p_preset_por;
    $rose(portPreset) |-> $past(sys_rst);
  endproperty
  a_preset_por: assert property (p_preset_por) else $error("port preset off power-on");
  // Selected pin low while running resets next cycle
  property p_pin_enter;
    (state == ST_RUN) && pinResetReq |=> (state == ST_HOLD) && cpuReset;
  endproperty
  a_pin_enter: assert property (p_pin_enter) else $error("pin reset missed");
  // Release delay lasts exactly its cycle count
  property p_release_time;
    (state == ST_RELEASE) && relDone |-> stateCyc == PIN_RELEASE_LOAD;
  endproperty
  a_release_time: assert property (p_release_time) else $error("release delay wrong");
  // Soft wait lasts exactly the soft delay
  property p_soft_time;
    fromSoft |-> (stateCyc == SOFT_RESET_LOAD) && !cpuReset;
  endproperty
  a_soft_time: assert property (p_soft_time) else $error("soft delay wrong");
  // Pin select soft reset sets bit 3 and restores the code
  property p_soft_flag;
    fromSoft && causePin |=> causeFlags[FLAG_PIN_SEL] && (pinSelect == PIN_SELECT_POR);
  endproperty
  a_soft_flag: assert property (p_soft_flag) else $error("pin select flag not set");
  // Bit 3 only falls on a software zero write
  property p_flag_sticky;
    causeFlags[FLAG_PIN_SEL] && !(wrFlags && !regWdata[FLAG_PIN_SEL])
      |=> causeFlags[FLAG_PIN_SEL];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hw");
  // Flag read shows zero upper half and the stored flags
  property p_upper_zero;
    regRd && (regAddr == ADDR_CAUSE_FLAGS)
      |=> (regRdata[7:4] == UPPER_ZERO) && (regRdata[3:0] == $past(causeFlags));
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("flag read wrong");
  // Reset code written makes the pin a reset input
  property p_override;
    wrPin && (regWdata == PIN_SEL_RESET) && !softBad && !lvFire && !wdtCtrlFault
      && !pinResetReq |=> resetPinEnable;
  endproperty
  a_override: assert property (p_override) else $error("pin not claimed");
  // Qualified dip keeps the threshold code and sets bit 2
  property p_lv_keep;
    (state == ST_RUN) && lvFire && !wrLv
      |=> $stable(lowVoltageSelect) && causeFlags[FLAG_UV_EVENT] && cpuReset;
  endproperty
  a_lv_keep: assert property (p_lv_keep) else $error("lv reset wrong");
  // Corrupt threshold code restores power-on value and sets bit 1
  property p_lv_bad;
    fromSoft && causeLv |=> (lowVoltageSelect == LV_SELECT_POR) && causeFlags[FLAG_UV_SEL];
  endproperty
  a_lv_bad: assert property (p_lv_bad) else $error("lv code reset wrong");
  // Idle or sleep switches monitoring off
  property p_idle;
    lowPowerMode |=> !lvMonitorEn;
  endproperty
  a_idle: assert property (p_idle) else $error("monitor on in low power");
  // Watchdog code fault sets bit 0
  property p_wdt;
    wdtCtrlFault |=> causeFlags[FLAG_WDT];
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog flag not set");

  // Main scenarios
  c_pin_reset: cover property ((state == ST_HOLD) && holdByPin ##1 (state == ST_RELEASE));
  c_soft_reset: cover property (fromSoft && causePin);
  c_lv_reset: cover property (lvFire && (state == ST_RUN));
  c_back_run: cover property ((state == ST_RELEASE) ##1 (state == ST_RUN));

endmodule
`default_nettype wire

// ### rsc_pkg.sv
// Constants, codes, state type and decode functions of the reset source controller.
// Assumes a 100 MHz system clock and a byte-wide register port.
package rsc_pkg;

  // Clock and timer width
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMER_W       = 10;

  // Delay figures in ns, turned into cycle counts (least times round up)
  localparam int SOFT_RESET_DELAY_NS       = 5000;
  localparam int PIN_RELEASE_DELAY_NS      = 3000;
  localparam int UNDERVOLTAGE_QUALIFY_NS   = 4000;
  localparam int SOFT_RESET_CYC  = (SOFT_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIN_RELEASE_CYC = (PIN_RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUALIFY_CYC     = (UNDERVOLTAGE_QUALIFY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Timer load and compare values
  localparam logic [TIMER_W-1:0] SOFT_RESET_LOAD  = TIMER_W'(SOFT_RESET_CYC - 1);
  localparam logic [TIMER_W-1:0] PIN_RELEASE_LOAD = TIMER_W'(PIN_RELEASE_CYC - 1);
  localparam logic [TIMER_W-1:0] QUALIFY_LAST     = TIMER_W'(QUALIFY_CYC - 1);
  localparam logic [TIMER_W-1:0] QUALIFY_SAT      = TIMER_W'(QUALIFY_CYC);
  localparam logic [TIMER_W-1:0] TIMER_ONE        = TIMER_W'(1);
  localparam logic [TIMER_W-1:0] TIMER_ZERO       = TIMER_W'(0);

  // Register map
  localparam logic [3:0] ADDR_PIN_SELECT  = 4'h0;
  localparam logic [3:0] ADDR_CAUSE_FLAGS = 4'h1;
  localparam logic [3:0] ADDR_LV_SELECT   = 4'h2;

  // Values after power-on
  localparam logic [7:0] PIN_SELECT_POR  = 8'h55;
  localparam logic [7:0] LV_SELECT_POR   = 8'h66;
  localparam logic [3:0] CAUSE_FLAGS_POR = 4'h0;
  localparam logic [3:0] UPPER_ZERO      = 4'h0;
  localparam logic [7:0] READ_IDLE       = 8'h00;

  // Reset pin selection codes
  localparam logic [7:0] PIN_SEL_IO    = 8'h55;
  localparam logic [7:0] PIN_SEL_RESET = 8'hAA;

  // Undervoltage threshold codes
  localparam logic [7:0] LV_CODE_1V7  = 8'h66;
  localparam logic [7:0] LV_CODE_1V9  = 8'h55;
  localparam logic [7:0] LV_CODE_2V55 = 8'h33;
  localparam logic [7:0] LV_CODE_3V15 = 8'h99;
  localparam logic [7:0] LV_CODE_3V8  = 8'hAA;
  localparam logic [7:0] LV_CODE_OFF  = 8'hF0;
  localparam logic [2:0] THR_NONE     = 3'h7;

  // Cause flag positions
  localparam int FLAG_PIN_SEL  = 3;
  localparam int FLAG_UV_EVENT = 2;
  localparam int FLAG_UV_SEL   = 1;
  localparam int FLAG_WDT      = 0;

  // Sequencer states, Gray along run, wait, hold, release
  typedef enum logic [1:0] {
    ST_RUN       = 2'b00,
    ST_SOFT_WAIT = 2'b01,
    ST_HOLD      = 2'b11,
    ST_RELEASE   = 2'b10
  } rsc_state_e;

  // Pin selection code is one of the two legal patterns
  function automatic logic pinSelValid(input logic [7:0] code);
    pinSelValid = (code == PIN_SEL_IO) || (code == PIN_SEL_RESET);
  endfunction

  // Threshold index 0..4, or none for disable and illegal codes
  function automatic logic [2:0] lvThresholdIndex(input logic [7:0] code);
    case (code)
      LV_CODE_1V7:  lvThresholdIndex = 3'h0;
      LV_CODE_1V9:  lvThresholdIndex = 3'h1;
      LV_CODE_2V55: lvThresholdIndex = 3'h2;
      LV_CODE_3V15: lvThresholdIndex = 3'h3;
      LV_CODE_3V8:  lvThresholdIndex = 3'h4;
      default:      lvThresholdIndex = THR_NONE;
    endcase
  endfunction

  // Threshold code or the disable code
  function automatic logic lvCodeValid(input logic [7:0] code);
    lvCodeValid = (lvThresholdIndex(code) != THR_NONE) || (code == LV_CODE_OFF);
  endfunction

endpackage

// ### rsc_delay_timer.sv
// One-shot down counter giving a done pulse a loaded number of cycles later.
// Assumes start is a one-cycle pulse; a new start restarts the count.
`timescale 1ns/1ps
`default_nettype none
module rsc_delay_timer
  import rsc_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               start,
  input  wire logic [TIMER_W-1:0] loadValue,
  output logic                    done
);

  logic [TIMER_W-1:0] count;

  // Load on start, then count down to zero and stop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= TIMER_ZERO;
    end else if (start) begin
      count <= loadValue;
    end else if (count != TIMER_ZERO) begin
      count <= count - TIMER_ONE;
    end
  end

  // Single pulse as the count leaves one
  always_ff @(posedge clk) begin
    if (sys_rst || start) begin
      done <= 1'b0;
    end else begin
      done <= (count == TIMER_ONE);
    end
  end

endmodule
`default_nettype wire

// ### rsc_supply_filter.sv
// Persistence filter for the low-supply comparator.
// Assumes the comparator output is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module rsc_supply_filter
  import rsc_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic monitorEn,
  input  wire logic supplyLow,
  output logic      qualified
);

  logic [TIMER_W-1:0] lowCnt;
  logic               lowNow;

  assign lowNow = monitorEn && supplyLow;

  // Count consecutive low samples, any high sample restarts
  always_ff @(posedge clk) begin
    if (sys_rst || !lowNow) begin
      lowCnt <= TIMER_ZERO;
    end else if (lowCnt != QUALIFY_SAT) begin
      lowCnt <= lowCnt + TIMER_ONE;
    end
  end

  // One pulse per episode once the dip outlasts the window
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      qualified <= 1'b0;
    end else begin
      qualified <= lowNow && (lowCnt == QUALIFY_LAST);
    end
  end

endmodule
`default_nettype wire

// ### rsc_supply_pin_model.sv
// Far side model: RC network on the reset pin and the supply comparator.
// Assumes bench commands change just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module rsc_supply_pin_model #(
  parameter int RC_CYC = 20
) (
  input  wire logic clk,
  input  wire logic pullLow,
  input  wire logic dropSupply,
  output logic      extResetNPin,
  output logic      supplyLow
);
  int chargeCnt = 0;

  // Capacitor charges after the pin is let go, so the pin rises late
  always @(posedge clk) begin
    if (pullLow) begin
      chargeCnt <= 0;
    end else if (chargeCnt < RC_CYC) begin
      chargeCnt <= chargeCnt + 1;
    end
  end
  assign extResetNPin = (chargeCnt >= RC_CYC);

  // Comparator output follows the supply dip
  assign supplyLow = dropSupply;
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the reset source controller.
// Assumes the far-side model file and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rsc_pkg::*;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       lowPowerMode = 1'b0;
  logic       wdtCtrlFault = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic       regWr = 1'b0;
  logic       regRd = 1'b0;
  logic       pullLow = 1'b0;
  logic       dropSupply = 1'b0;
  wire        extResetNPin;
  wire        supplyLow;
  logic [7:0] regRdata;
  logic       cpuReset;
  logic       portPreset;
  logic       resetPinEnable;
  logic       lvMonitorEn;
  logic [2:0] lvThreshold;
  int         err_total = 0;
  int         check_count = 0;
  int         n;

  // 100 MHz clock
  always #5 clk = ~clk;

  rsc_supply_pin_model #(.RC_CYC(20)) farSide (.clk(clk), .pullLow(pullLow),
    .dropSupply(dropSupply), .extResetNPin(extResetNPin), .supplyLow(supplyLow));

  rsc_reset_source_control DUT (.clk(clk), .sys_rst(sys_rst), .extResetNPin(extResetNPin),
    .supplyLow(supplyLow), .lowPowerMode(lowPowerMode), .wdtCtrlFault(wdtCtrlFault),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .cpuReset(cpuReset), .portPreset(portPreset),
    .resetPinEnable(resetPinEnable), .lvMonitorEn(lvMonitorEn), .lvThreshold(lvThreshold));

  // Comparisons
  task automatic cmp8(input logic [7:0] act, input logic [7:0] exp);
    check_count++;
    if (act !== exp) begin
      err_total++;
      $display("[ERR] %0t byte %h expected %h", $time, act, exp);
    end
  endtask
  task automatic cmp1(input logic act, input logic exp);
    check_count++;
    if (act !== exp) begin
      err_total++;
      $display("[ERR] %0t bit %b expected %b", $time, act, exp);
    end
  endtask

  // Register port cycles
  task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) begin
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
    end
    @(posedge clk) regWr <= 1'b0;
    #1;
  endtask
  task automatic rdReg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk) begin
      regRd   <= 1'b1;
      regAddr <= a;
    end
    @(posedge clk) regRd <= 1'b0;
    #1 cmp8(regRdata, exp);
  endtask
  // Bounded wait for the CPU reset level
  task automatic waitCpu(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (cpuReset !== lvl && cnt < lim) begin
      @(posedge clk);
      #1 cnt++;
    end
    cmp1(cpuReset, lvl);
  endtask

  task automatic testPowerOn();
    repeat (7) @(posedge clk);
    #1 cmp1(cpuReset, 1'b1);
    cmp1(portPreset, 1'b1);
    @(posedge clk) sys_rst <= 1'b0;
    waitCpu(1'b0, 400, n);
    cmp1(n >= PIN_RELEASE_CYC, 1'b1);
    cmp1(portPreset, 1'b0);
    cmp1(lvMonitorEn, 1'b1);
    cmp8({5'h0, lvThreshold}, 8'h00);
    rdReg(ADDR_PIN_SELECT, PIN_SELECT_POR);
    rdReg(ADDR_LV_SELECT, LV_SELECT_POR);
    rdReg(ADDR_CAUSE_FLAGS, 8'h00);
    rdReg(4'hF, READ_IDLE);
  endtask

  task automatic testPinReset();
    wrReg(ADDR_PIN_SELECT, PIN_SEL_RESET);
    cmp1(resetPinEnable, 1'b1);
    @(posedge clk) pullLow <= 1'b1;
    waitCpu(1'b1, 10, n);
    cmp1(portPreset, 1'b0);
    repeat (50) @(posedge clk);
    #1 cmp1(cpuReset, 1'b1);
    @(posedge clk) pullLow <= 1'b0;
    waitCpu(1'b0, 600, n);
    cmp1(n >= PIN_RELEASE_CYC + 20, 1'b1);
    rdReg(ADDR_PIN_SELECT, PIN_SEL_IO);
    cmp1(resetPinEnable, 1'b0);
    // Pin in I/O use: a low level must not reset
    @(posedge clk) pullLow <= 1'b1;
    repeat (30) @(posedge clk);
    #1 cmp1(cpuReset, 1'b0);
    @(posedge clk) pullLow <= 1'b0;
    repeat (25) @(posedge clk);
  endtask

  task automatic testPinSelSoft();
    wrReg(ADDR_PIN_SELECT, 8'h12);
    repeat (400) @(posedge clk);
    #1 cmp1(cpuReset, 1'b0);
    waitCpu(1'b1, 200, n);
    waitCpu(1'b0, 400, n);
    rdReg(ADDR_CAUSE_FLAGS, 8'h08);
    @(posedge clk);
    #1 cmp8(regRdata, READ_IDLE);
    rdReg(ADDR_PIN_SELECT, PIN_SELECT_POR);
    wrReg(ADDR_CAUSE_FLAGS, 8'hFF);
    rdReg(ADDR_CAUSE_FLAGS, 8'h08);
    wrReg(ADDR_CAUSE_FLAGS, 8'h00);
    rdReg(ADDR_CAUSE_FLAGS, 8'h00);
  endtask

  task automatic testLvCodes();
    logic [7:0] codes [6];
    logic [2:0] idx [6];
    codes = '{LV_CODE_1V7, LV_CODE_1V9, LV_CODE_2V55, LV_CODE_3V15, LV_CODE_3V8, LV_CODE_OFF};
    idx = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, THR_NONE};
    for (int i = 0; i < 6; i++) begin
      wrReg(ADDR_LV_SELECT, codes[i]);
      cmp8({5'h0, lvThreshold}, {5'h0, idx[i]});
      cmp1(lvMonitorEn, i < 5);
      rdReg(ADDR_LV_SELECT, codes[i]);
    end
    wrReg(ADDR_LV_SELECT, LV_CODE_2V55);
    @(posedge clk) lowPowerMode <= 1'b1;
    @(posedge clk) dropSupply <= 1'b1;
    #1 cmp1(lvMonitorEn, 1'b0);
    repeat (500) @(posedge clk);
    #1 cmp1(cpuReset, 1'b0);
    @(posedge clk) dropSupply <= 1'b0;
    @(posedge clk) lowPowerMode <= 1'b0;
  endtask

  task automatic testUndervoltage();
    @(posedge clk) dropSupply <= 1'b1;
    repeat (100) @(posedge clk);
    dropSupply <= 1'b0;
    repeat (20) @(posedge clk);
    #1 cmp1(cpuReset, 1'b0);
    @(posedge clk) dropSupply <= 1'b1;
    waitCpu(1'b1, 450, n);
    cmp1(n >= QUALIFY_CYC - 1, 1'b1);
    @(posedge clk) dropSupply <= 1'b0;
    waitCpu(1'b0, 400, n);
    rdReg(ADDR_CAUSE_FLAGS, 8'h04);
    rdReg(ADDR_LV_SELECT, LV_CODE_2V55);
    wrReg(ADDR_CAUSE_FLAGS, 8'h00);
  endtask

  task automatic testLvSoftAndWdt();
    wrReg(ADDR_LV_SELECT, 8'h12);
    waitCpu(1'b1, 600, n);
    cmp1(n >= SOFT_RESET_CYC - 2, 1'b1);
    waitCpu(1'b0, 400, n);
    rdReg(ADDR_CAUSE_FLAGS, 8'h02);
    rdReg(ADDR_LV_SELECT, LV_SELECT_POR);
    wrReg(ADDR_CAUSE_FLAGS, 8'h00);
    @(posedge clk) wdtCtrlFault <= 1'b1;
    @(posedge clk) wdtCtrlFault <= 1'b0;
    waitCpu(1'b1, 5, n);
    waitCpu(1'b0, 400, n);
    rdReg(ADDR_CAUSE_FLAGS, 8'h01);
    wrReg(ADDR_CAUSE_FLAGS, 8'h00);
    rdReg(ADDR_CAUSE_FLAGS, 8'h00);
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    testPowerOn();
    testPinReset();
    testPinSelSoft();
    testLvCodes();
    testUndervoltage();
    testLvSoftAndWdt();
    end_of_test();
  end

  // Hang guard, about five times the expected run
  initial begin
    #200000;
    err_total++;
    end_of_test();
  end
endmodule
`default_nettype wire
